// File: rtl/led_hyst_pkg.sv
package led_hyst_pkg;

    localparam int NUM_CH = 3;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int SPI_FRAME_BITS = 16;
    localparam int SPI_HDR_BITS = 8;

    localparam logic [6:0] ADDR_HYST_CH1 = 7'h0b;
    localparam logic [6:0] ADDR_HYST_CH2 = 7'h0c;
    localparam logic [6:0] ADDR_HYST_CH3 = 7'h0d;
    localparam logic [6:0] ADDR_VOUT_ON_CH1 = 7'h20;
    localparam logic [6:0] ADDR_VOUT_OFF_CH1 = 7'h21;
    localparam logic [6:0] ADDR_VOUT_ON_CH2 = 7'h22;
    localparam logic [6:0] ADDR_VOUT_OFF_CH2 = 7'h23;
    localparam logic [6:0] ADDR_VOUT_ON_CH3 = 7'h24;
    localparam logic [6:0] ADDR_VOUT_OFF_CH3 = 7'h25;

    localparam int HYST_SEL_LSB = 0;
    localparam int HYST_SEL_W = 2;
    localparam logic [1:0] HYST_SEL_RESET = 2'h0;
    localparam logic [7:0] VOUT_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam int CLK_PERIOD_NS = 10;
    localparam int OC_OFF_TIME_MS = 16;
    localparam int OC_OFF_CYCLES = OC_OFF_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int MEAS_PERIOD_US = 10;
    localparam int MEAS_PERIOD_CYCLES = MEAS_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int STATIC_REFRESH_US = 1000;
    localparam int STATIC_REFRESH_CYCLES = STATIC_REFRESH_US * 1000 / CLK_PERIOD_NS;

    // Sync bit order: {oc[2:0], dim[2:0], mosi, csn, sck}
    localparam logic [8:0] SYNC_RESET = 9'h002;

    typedef struct packed {
        logic gate_on;
        logic [1:0] hyst_sel;
        logic current_range;
    } ch_drive_s;

    typedef enum {SPI_IDLE, SPI_HEADER, SPI_DATA, SPI_DONE} spi_state_e;

endpackage

// File: rtl/led_hyst_vout_capture_regs.sv
`timescale 1ns/1ps

module led_hyst_vout_capture_regs #(
    parameter int OC_OFF_CYCLES = led_hyst_pkg::OC_OFF_CYCLES,
    parameter int MEAS_PERIOD_CYCLES = led_hyst_pkg::MEAS_PERIOD_CYCLES,
    parameter int STATIC_REFRESH_CYCLES = led_hyst_pkg::STATIC_REFRESH_CYCLES
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic SCK,
    input wire logic CSN,
    input wire logic MOSI,
    output logic MISO_O,
    output logic MISO_OE,
    input wire logic [2:0] DIM_INPUT,
    input wire logic [2:0] DIM_INPUT_ENABLE,
    input wire logic [2:0] CURRENT_RANGE,
    input wire logic [2:0] OVERCURRENT,
    input wire logic [2:0][7:0] VOUT_CODE,
    output led_hyst_pkg::ch_drive_s [2:0] CH_DRIVE
);

    localparam int OC_W = $clog2(OC_OFF_CYCLES + 1);
    localparam int MEAS_W = $clog2(MEAS_PERIOD_CYCLES + 1);
    localparam int STAT_W = $clog2(STATIC_REFRESH_CYCLES + 1);
    localparam logic [OC_W-1:0] OC_LOAD = OC_W'(OC_OFF_CYCLES);
    localparam logic [MEAS_W-1:0] MEAS_LAST = MEAS_W'(MEAS_PERIOD_CYCLES - 1);
    localparam logic [STAT_W-1:0] STAT_LAST = STAT_W'(STATIC_REFRESH_CYCLES - 1);

    logic [8:0] meta_reg;
    logic [8:0] sync_reg;
    logic sck_s;
    logic csn_s;
    logic mosi_s;
    logic [2:0] dim_s;
    logic [2:0] oc_s;
    logic sck_prev_reg;
    logic sck_rise;
    logic sck_fall;

    led_hyst_pkg::spi_state_e spi_state_reg;
    logic [3:0] bit_cnt_reg;
    logic [14:0] shift_reg;
    logic [7:0] tx_reg;
    logic wr_cmd_reg;
    logic [6:0] addr_reg;
    logic miso_reg;
    logic miso_oe_reg;
    logic [7:0] hdr_byte;
    logic [7:0] wr_byte;
    logic wr_strobe;

    logic [1:0] hyst_reg [3];
    logic [7:0] vout_high_reg [3];
    logic [7:0] vout_low_reg [3];

    logic [MEAS_W-1:0] meas_cnt_reg;
    logic meas_tick;
    logic [7:0] latest_reg [3];
    logic [2:0] latest_level_reg;
    logic [2:0] latest_valid_reg;
    logic [2:0] dim_prev_reg;
    logic [STAT_W-1:0] stat_cnt_reg [3];
    logic [OC_W-1:0] oc_cnt_reg [3];

    function automatic logic [7:0] reg_read(input logic [6:0] addr);
        logic [7:0] val;
        val = led_hyst_pkg::UNMAPPED_READ;
        case (addr)
            led_hyst_pkg::ADDR_HYST_CH1: val = {6'h00, hyst_reg[0]};
            led_hyst_pkg::ADDR_HYST_CH2: val = {6'h00, hyst_reg[1]};
            led_hyst_pkg::ADDR_HYST_CH3: val = {6'h00, hyst_reg[2]};
            led_hyst_pkg::ADDR_VOUT_ON_CH1: val = vout_high_reg[0];
            led_hyst_pkg::ADDR_VOUT_OFF_CH1: val = vout_low_reg[0];
            led_hyst_pkg::ADDR_VOUT_ON_CH2: val = vout_high_reg[1];
            led_hyst_pkg::ADDR_VOUT_OFF_CH2: val = vout_low_reg[1];
            led_hyst_pkg::ADDR_VOUT_ON_CH3: val = vout_high_reg[2];
            led_hyst_pkg::ADDR_VOUT_OFF_CH3: val = vout_low_reg[2];
            default: val = led_hyst_pkg::UNMAPPED_READ;
        endcase
        return val;
    endfunction

    // The SPI, dim and overcurrent pins pass two flops; only sync_reg is read by logic
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            meta_reg <= led_hyst_pkg::SYNC_RESET;
            sync_reg <= led_hyst_pkg::SYNC_RESET;
        end else begin
            meta_reg <= {OVERCURRENT, DIM_INPUT, MOSI, CSN, SCK};
            sync_reg <= meta_reg;
        end
    end

    assign sck_s = sync_reg[0];
    assign csn_s = sync_reg[1];
    assign mosi_s = sync_reg[2];
    assign dim_s = sync_reg[5:3];
    assign oc_s = sync_reg[8:6];

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev_reg & ~csn_s;
    assign sck_fall = ~sck_s & sck_prev_reg & ~csn_s;
    assign hdr_byte = {shift_reg[6:0], mosi_s};
    assign wr_byte = {shift_reg[6:0], mosi_s};
    assign wr_strobe = (spi_state_reg == led_hyst_pkg::SPI_DATA) && sck_rise &&
                       (bit_cnt_reg == 4'(led_hyst_pkg::SPI_FRAME_BITS - 1)) && wr_cmd_reg;

    // Frame: bit 15 write flag, bits 14:8 address, bits 7:0 data, MSB first
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            spi_state_reg <= led_hyst_pkg::SPI_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 15'h0000;
            tx_reg <= 8'h00;
            wr_cmd_reg <= 1'b0;
            addr_reg <= 7'h00;
        end else if (csn_s) begin
            spi_state_reg <= led_hyst_pkg::SPI_IDLE;
            bit_cnt_reg <= 4'h0;
        end else begin
            case (spi_state_reg)
                led_hyst_pkg::SPI_IDLE: begin
                    spi_state_reg <= led_hyst_pkg::SPI_HEADER;
                end
                led_hyst_pkg::SPI_HEADER: begin
                    if (sck_rise) begin
                        shift_reg <= {shift_reg[13:0], mosi_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'(led_hyst_pkg::SPI_HDR_BITS - 1)) begin
                            wr_cmd_reg <= hdr_byte[7];
                            addr_reg <= hdr_byte[6:0];
                            tx_reg <= reg_read(hdr_byte[6:0]);
                            spi_state_reg <= led_hyst_pkg::SPI_DATA;
                        end
                    end
                end
                led_hyst_pkg::SPI_DATA: begin
                    if (sck_rise) begin
                        shift_reg <= {shift_reg[13:0], mosi_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'(led_hyst_pkg::SPI_FRAME_BITS - 1)) begin
                            spi_state_reg <= led_hyst_pkg::SPI_DONE;
                        end
                    end else if (sck_fall) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                    end
                end
                led_hyst_pkg::SPI_DONE: begin
                    spi_state_reg <= led_hyst_pkg::SPI_DONE;
                end
                default: begin
                    spi_state_reg <= led_hyst_pkg::SPI_IDLE;
                end
            endcase
        end
    end

    // Data bit leaves on the falling edge so it is stable at the next rise
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            miso_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else begin
            miso_oe_reg <= ~csn_s;
            if (csn_s) begin
                miso_reg <= 1'b0;
            end else if (sck_fall && spi_state_reg == led_hyst_pkg::SPI_DATA && !wr_cmd_reg) begin
                miso_reg <= tx_reg[7];
            end
        end
    end

    assign MISO_O = miso_reg;
    assign MISO_OE = miso_oe_reg;

    // Reserved bits are dropped, so they always read back as zero
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                hyst_reg[i] <= led_hyst_pkg::HYST_SEL_RESET;
            end
        end else if (wr_strobe) begin
            case (addr_reg)
                led_hyst_pkg::ADDR_HYST_CH1: hyst_reg[0] <= wr_byte[1:0];
                led_hyst_pkg::ADDR_HYST_CH2: hyst_reg[1] <= wr_byte[1:0];
                led_hyst_pkg::ADDR_HYST_CH3: hyst_reg[2] <= wr_byte[1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            meas_cnt_reg <= '0;
        end else if (meas_cnt_reg == MEAS_LAST) begin
            meas_cnt_reg <= '0;
        end else begin
            meas_cnt_reg <= meas_cnt_reg + MEAS_W'(1);
        end
    end

    assign meas_tick = (meas_cnt_reg == MEAS_LAST);

    // Each sample is tagged with the dim level it was taken under
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            latest_level_reg <= 3'h0;
            latest_valid_reg <= 3'h0;
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                latest_reg[i] <= led_hyst_pkg::VOUT_RESET;
            end
        end else if (meas_tick) begin
            latest_level_reg <= dim_s;
            latest_valid_reg <= 3'h7;
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                latest_reg[i] <= VOUT_CODE[i];
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            dim_prev_reg <= 3'h0;
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                stat_cnt_reg[i] <= '0;
            end
        end else begin
            dim_prev_reg <= dim_s;
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                if (dim_s[i] != dim_prev_reg[i] || stat_cnt_reg[i] == STAT_LAST) begin
                    stat_cnt_reg[i] <= '0;
                end else begin
                    stat_cnt_reg[i] <= stat_cnt_reg[i] + STAT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                vout_high_reg[i] <= led_hyst_pkg::VOUT_RESET;
                vout_low_reg[i] <= led_hyst_pkg::VOUT_RESET;
            end
        end else begin
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                if (latest_valid_reg[i]) begin
                    if (dim_s[i] != dim_prev_reg[i]) begin
                        if (latest_level_reg[i]) begin
                            vout_high_reg[i] <= latest_reg[i];
                        end else begin
                            vout_low_reg[i] <= latest_reg[i];
                        end
                    end else if (stat_cnt_reg[i] == STAT_LAST) begin
                        vout_high_reg[i] <= latest_reg[i];
                        vout_low_reg[i] <= latest_reg[i];
                    end
                end
            end
        end
    end

    // Retrigger while the comparator still trips, so a hard fault never restarts
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                oc_cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                if (oc_s[i] && oc_cnt_reg[i] == '0) begin
                    oc_cnt_reg[i] <= OC_LOAD;
                end else if (oc_cnt_reg[i] != '0) begin
                    oc_cnt_reg[i] <= oc_cnt_reg[i] - OC_W'(1);
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            CH_DRIVE <= '0;
        end else begin
            for (int i = 0; i < led_hyst_pkg::NUM_CH; i++) begin
                CH_DRIVE[i].gate_on <= DIM_INPUT_ENABLE[i] & dim_s[i] & ~oc_s[i] &
                                       (oc_cnt_reg[i] == '0);
                CH_DRIVE[i].hyst_sel <= hyst_reg[i];
                CH_DRIVE[i].current_range <= CURRENT_RANGE[i];
            end
        end
    end

endmodule

// File: verif/led_hyst_vout_capture_regs_props.sv
`timescale 1ns/1ps
module led_hyst_props #(
    parameter int OC_OFF_CYCLES = 20,
    parameter int MEAS_PERIOD_CYCLES = 4,
    parameter int STATIC_REFRESH_CYCLES = 2000
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic SCK,
    input wire logic CSN,
    input wire logic MOSI,
    input wire logic MISO_O,
    input wire logic MISO_OE,
    input wire logic [2:0] DIM_INPUT,
    input wire logic [2:0] DIM_INPUT_ENABLE,
    input wire logic [2:0] CURRENT_RANGE,
    input wire logic [2:0] OVERCURRENT,
    input wire logic [2:0][7:0] VOUT_CODE,
    input wire led_hyst_pkg::ch_drive_s [2:0] CH_DRIVE
);
    // Slack covers the pin synchroniser and the reload while the fault is still high
    localparam int OC_MAX = OC_OFF_CYCLES + 8;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    sequence run_s;
        DIM_INPUT[0] && DIM_INPUT_ENABLE[0] && !OVERCURRENT[0];
    endsequence
    sequence oc_off_s;
        ##3 (!CH_DRIVE[0].gate_on) [*8];
    endsequence
    chk_oc_cut: assert property ($rose(OVERCURRENT[0]) |-> oc_off_s)
        else $error("gate not cut by overcurrent");
    chk_oc_restart: assert property (($fell(OVERCURRENT[0]) ##0 run_s) |->
        ((DIM_INPUT[0] && DIM_INPUT_ENABLE[0] && !OVERCURRENT[0]) throughout
        ##[1:OC_MAX] CH_DRIVE[0].gate_on))
        else $error("no restart after lockout");
    chk_dim_gate: assert property (!DIM_INPUT[0] [*4] |-> !CH_DRIVE[0].gate_on)
        else $error("gate on with dim low");
    chk_gate_cause: assert property ($rose(CH_DRIVE[2].gate_on) |-> $past(DIM_INPUT[2], 3))
        else $error("gate rose without dim high");
    chk_en_gate: assert property (!DIM_INPUT_ENABLE[1] [*4] |-> !CH_DRIVE[1].gate_on)
        else $error("gate on while disabled");
    chk_hyst_indep: assert property ((CSN [*8] ##0 $changed(CURRENT_RANGE)) |=>
        $stable(CH_DRIVE[0].hyst_sel) [*2])
        else $error("range change moved hysteresis");
    chk_range_pass: assert property ($stable(CURRENT_RANGE) [*4] |->
        CH_DRIVE[2].current_range == CURRENT_RANGE[2])
        else $error("range not passed through");
    chk_miso_off: assert property (CSN [*4] |-> !MISO_OE && !MISO_O)
        else $error("data line driven while deselected");
    chk_miso_on: assert property (!CSN [*4] |-> MISO_OE)
        else $error("data line not driven while selected");
endmodule

bind led_hyst_vout_capture_regs led_hyst_props #(.OC_OFF_CYCLES(OC_OFF_CYCLES),
    .MEAS_PERIOD_CYCLES(MEAS_PERIOD_CYCLES), .STATIC_REFRESH_CYCLES(STATIC_REFRESH_CYCLES))
    led_hyst_props_i (.MCLK(MCLK), .RESETN(RESETN), .SCK(SCK), .CSN(CSN), .MOSI(MOSI),
    .MISO_O(MISO_O), .MISO_OE(MISO_OE), .DIM_INPUT(DIM_INPUT),
    .DIM_INPUT_ENABLE(DIM_INPUT_ENABLE), .CURRENT_RANGE(CURRENT_RANGE),
    .OVERCURRENT(OVERCURRENT), .VOUT_CODE(VOUT_CODE), .CH_DRIVE(CH_DRIVE));

// File: verif/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    output logic sck,
    output logic csn,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        csn = 1'b1;
        mosi = 1'b0;
    end
    // Fewer than 16 bits aborts the frame by raising select early
    task automatic xfer(input logic [15:0] f, input int nb, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clk);
        csn = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 15; i > 15 - nb; i--) begin
            mosi = f[i];
            repeat (6) @(negedge clk);
            sck = 1'b1;
            if (i < 8) rd[i] = miso;
            repeat (6) @(negedge clk);
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        csn = 1'b1;
        mosi = ~mosi;
        repeat (4) @(negedge clk);
    endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, sck, csn, mosi, miso_o, miso_oe, miso_w;
    logic miso_last = 1'b0;
    logic [2:0] dim, en, rng, oc;
    logic [2:0][7:0] vout;
    led_hyst_pkg::ch_drive_s [2:0] drv;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] r;
    led_hyst_vout_capture_regs #(.OC_OFF_CYCLES(20), .MEAS_PERIOD_CYCLES(4),
        .STATIC_REFRESH_CYCLES(2000)) led_hyst_vout_capture_regs_i (.MCLK(clk),
        .RESETN(rst_n), .SCK(sck), .CSN(csn), .MOSI(mosi), .MISO_O(miso_o),
        .MISO_OE(miso_oe), .DIM_INPUT(dim), .DIM_INPUT_ENABLE(en), .CURRENT_RANGE(rng),
        .OVERCURRENT(oc), .VOUT_CODE(vout), .CH_DRIVE(drv));
    spi_host_model spi_host_model_i (.clk(clk), .sck(sck), .csn(csn), .mosi(mosi),
        .miso(miso_w));
    // Released line shows the inverse so a stale bit never reads as valid
    always @(posedge clk) if (miso_oe) miso_last <= miso_o;
    assign miso_w = miso_oe ? miso_o : ~miso_last;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            $display("BAD %0t timeout", $time);
            end_of_test();
        end
    end
    task end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi_host_model_i.xfer({1'b1, a, d}, 16, x);
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        spi_host_model_i.xfer({1'b0, a, 8'h00}, 16, d);
        chk(d, e);
    endtask
    function automatic logic [6:0] vaddr(input int c, input int off);
        return led_hyst_pkg::ADDR_VOUT_ON_CH1 + 7'(2 * c + off);
    endfunction
    task automatic t_reset;
        for (int c = 0; c < 3; c++) begin
            rchk(led_hyst_pkg::ADDR_HYST_CH1 + 7'(c), 8'h00);
            rchk(vaddr(c, 0), 8'h00);
            rchk(vaddr(c, 1), 8'h00);
        end
        rchk(7'h30, led_hyst_pkg::UNMAPPED_READ);
        wr(vaddr(0, 0), 8'hff);
        rchk(vaddr(0, 0), 8'h00);
        spi_host_model_i.xfer({1'b1, led_hyst_pkg::ADDR_HYST_CH1, 8'h02}, 12, r);
        rchk(led_hyst_pkg::ADDR_HYST_CH1, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_capture;
        for (int c = 0; c < 3; c++) wr(led_hyst_pkg::ADDR_HYST_CH1 + 7'(c), 8'h00);
        for (int c = 0; c < 3; c++) vout[c] = 8'h10 + 8'(c);
        repeat (12) @(negedge clk);
        dim = 3'b111;
        repeat (12) @(negedge clk);
        for (int c = 0; c < 3; c++) vout[c] = 8'h20 + 8'(c);
        repeat (12) @(negedge clk);
        dim = 3'b000;
        repeat (8) @(negedge clk);
        for (int c = 0; c < 3; c++) begin
            rchk(vaddr(c, 0), 8'h20 + 8'(c));
            rchk(vaddr(c, 1), 8'h10 + 8'(c));
        end
        for (int c = 0; c < 3; c++) vout[c] = 8'h30 + 8'(c);
        repeat (2100) @(negedge clk);
        for (int c = 0; c < 3; c++) begin
            rchk(vaddr(c, 0), 8'h30 + 8'(c));
            rchk(vaddr(c, 1), 8'h30 + 8'(c));
        end
        $display("t_capture done");
    endtask
    task automatic t_gate;
        en = 3'b111;
        dim = 3'b111;
        repeat (6) @(negedge clk);
        chk(8'({drv[2].gate_on, drv[1].gate_on, drv[0].gate_on}), 8'h07);
        en = 3'b101;
        dim = 3'b110;
        repeat (6) @(negedge clk);
        chk(8'({drv[2].gate_on, drv[1].gate_on, drv[0].gate_on}), 8'h04);
        en = 3'b111;
        dim = 3'b111;
        repeat (6) @(negedge clk);
        oc = 3'b001;
        repeat (2) @(negedge clk);
        oc = 3'b000;
        repeat (3) @(negedge clk);
        chk(8'(drv[0].gate_on), 8'h00);
        repeat (10) @(negedge clk);
        chk(8'(drv[0].gate_on), 8'h00);
        repeat (25) @(negedge clk);
        chk(8'(drv[0].gate_on), 8'h01);
        $display("t_gate done");
    endtask
    task automatic t_hyst;
        for (int v = 0; v < 4; v++) begin
            for (int c = 0; c < 3; c++) begin
                wr(led_hyst_pkg::ADDR_HYST_CH1 + 7'(c), {6'h00, 2'(v)});
                repeat (8) @(negedge clk);
                rng = ~rng;
                repeat (8) @(negedge clk);
                chk(8'(drv[c].hyst_sel), 8'(v));
                chk(8'(drv[c].gate_on), 8'h01);
                chk(8'(drv[c].current_range), 8'(rng[c]));
                rchk(led_hyst_pkg::ADDR_HYST_CH1 + 7'(c), 8'(v));
            end
        end
        $display("t_hyst done");
    endtask
    initial begin
        rst_n = 1'b0;
        dim = 3'b000;
        en = 3'b000;
        rng = 3'b000;
        oc = 3'b000;
        vout = '0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_capture();
        t_gate();
        t_hyst();
        end_of_test();
    end
endmodule
